//--- src/cmb_consts.svh
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH
`define CMB_OFS_DIRECTION 4'h0
`define CMB_OFS_PENDING   4'h1
`define CMB_OFS_TRANSMIT_DONE_ACK     4'h2
`define CMB_OFS_CANCEL    4'h3
`define CMB_OFS_CANCEL_DONE_ACK     4'h4
`define CMB_OFS_RXDONE    4'h5
`define CMB_OFS_REMOTE    4'h6
`define CMB_OFS_IFLAGS    4'h7
`define CMB_OFS_IMASK     4'h8
`define CMB_OFS_CTRL      4'h9
`define CMB_IMASK_RESET   16'hffff
`define CMB_IFLAGS_RESET  16'h0001
`define CMB_WARN_LIMIT    9'h060
`define CMB_PASSIVE_LIMIT 9'h080
`define CMB_BUSOFF_LIMIT  9'h100
`define CMB_F_RESET_DONE  0
`define CMB_F_RX_MSG      1
`define CMB_F_REMOTE      2
`define CMB_F_TX_WARN     3
`define CMB_F_RX_WARN     4
`define CMB_F_PASSIVE     5
`define CMB_F_BUS_OFF     6
`define CMB_F_OVERLOAD    7
`define CMB_F_MB_EMPTY    8
`define CMB_F_OVERWRITE   9
`define CMB_F_BUS_ACT     12
`endif

//--- src/cmb_pkg.sv
package cmb_pkg;
	// Per-mailbox event strobes coming from the protocol engine.
	typedef struct packed {
		logic [15:0] tx_done;
		logic [15:0] cancel_done;
		logic [15:0] rx_done;
		logic [15:0] rx_remote;
	} cmb_mb_ev_t;
	// Controller-wide events and counter values.
	typedef struct packed {
		logic [8:0] tec;
		logic [7:0] rec;
		logic       overload;
		logic       overwrite;
		logic       bus_activity;
		logic       reset_busy;
	} cmb_ctl_ev_t;
	// Bus handshake phase of the register slave.
	typedef enum logic [0:0] {
		CMB_IDLE = 1'b0,
		CMB_ANS  = 1'b1
	} cmb_bus_t;
endpackage

//--- src/cmb_mailbox_flags.sv
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "cmb_consts.svh"
module cmb_mailbox_flags (
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic [3:0]         avs_address_in,
	input  wire logic               avs_read_in,
	input  wire logic               avs_write_in,
	input  wire logic [31:0]        avs_writedata_in,
	output logic      [31:0]        avs_readdata_out,
	output logic                    avs_waitrequest_out,
	input  wire cmb_pkg::cmb_mb_ev_t mb_ev_in,
	input  wire cmb_pkg::cmb_ctl_ev_t ctl_ev_in,
	input  wire logic               sleep_mode_in,
	output logic      [15:0]        tx_request_out,
	output logic      [15:0]        cancel_request_out,
	output logic      [15:0]        rx_enable_out,
	output logic                    sleep_release_out,
	output logic                    irq_out
);
	// Handshake phase: every access waits exactly one cycle.
	// A fixed single wait state keeps the read mux off the critical
	// path, at the cost of one extra cycle per access. Masters must
	// not assume a zero-wait answer.
	cmb_pkg::cmb_bus_t phase;
	// Software-visible registers.
	logic [15:0] direction;
	logic [15:0] pending;
	logic [15:0] transmit_done_ack;
	logic [15:0] cancel;
	logic [15:0] cancel_done_ack;
	logic [15:0] rxdone;
	logic [15:0] remote;
	logic [15:0] iflags;
	logic [15:0] imask;
	logic        release_en;
	// Remembers that a controller reset was seen until the reset-done flag is set.
	logic        rst_seen;
	// Previous counter threshold state, so flags set on crossing.
	logic        tx_warn_q;
	logic        rx_warn_q;
	logic        passive_q;
	logic        busoff_q;

	// A write takes effect only at the edge it is answered.
	// Decoding the strobe together with the answer phase means a
	// request that is held for the wait state is applied only once.
	// All register selects below share this single qualifier.
	wire acc     = (avs_read_in | avs_write_in) & (phase == cmb_pkg::CMB_ANS);
	wire wr      = avs_write_in & (phase == cmb_pkg::CMB_ANS);
	wire [15:0] wd = avs_writedata_in[15:0];
	wire wr_dir  = wr & (avs_address_in == `CMB_OFS_DIRECTION);
	wire wr_pend = wr & (avs_address_in == `CMB_OFS_PENDING);
	wire wr_txa  = wr & (avs_address_in == `CMB_OFS_TRANSMIT_DONE_ACK);
	wire wr_can  = wr & (avs_address_in == `CMB_OFS_CANCEL);
	wire wr_aba  = wr & (avs_address_in == `CMB_OFS_CANCEL_DONE_ACK);
	wire wr_rxd  = wr & (avs_address_in == `CMB_OFS_RXDONE);
	wire wr_rem  = wr & (avs_address_in == `CMB_OFS_REMOTE);
	wire wr_irr  = wr & (avs_address_in == `CMB_OFS_IFLAGS);
	wire wr_imr  = wr & (avs_address_in == `CMB_OFS_IMASK);
	wire wr_ctl  = wr & (avs_address_in == `CMB_OFS_CTRL);
	// Mailbox 0 is receive-only; its transmit bits never exist.
	wire [15:0] tx_mask = 16'hfffe;

	// Threshold comparisons of the error counters.
	// The receive counter is widened by one zero bit so that all
	// comparisons run against the same nine-bit limits.
	// Flags are raised on the rising crossing, not on the level.
	wire tx_warn = ctl_ev_in.tec >= `CMB_WARN_LIMIT;
	wire rx_warn = {1'b0, ctl_ev_in.rec} >= `CMB_WARN_LIMIT;
	wire passive = (ctl_ev_in.tec >= `CMB_PASSIVE_LIMIT) |
		({1'b0, ctl_ev_in.rec} >= `CMB_PASSIVE_LIMIT);
	wire busoff  = ctl_ev_in.tec >= `CMB_BUSOFF_LIMIT;

	// Completion events only count while the mailbox is pending.
	wire [15:0] tx_fin  = mb_ev_in.tx_done & pending & tx_mask;
	// A frame that finished wins over a late cancel.
	wire [15:0] can_fin = mb_ev_in.cancel_done & pending & tx_mask & ~tx_fin;

	// Next values of the per-mailbox flag registers.
	// Each hardware-set bit is ORed in after the software clear, so a
	// set event that meets a clearing write in the same cycle wins.
	// Writing 0 to any of these bits leaves it as it was.
	wire [15:0] next_pending = ((pending & ~tx_fin & ~can_fin) |
		(wr_pend ? wd : 16'h0000)) & tx_mask;
	wire [15:0] next_cancel = ((cancel & ~tx_fin & ~can_fin) |
		(wr_can ? (wd & pending) : 16'h0000)) & tx_mask;
	wire [15:0] next_transmit_done_ack = tx_fin |
		(transmit_done_ack & ~(wr_txa ? wd : 16'h0000));
	wire [15:0] next_cancel_done_ack = can_fin |
		(cancel_done_ack & ~(wr_aba ? wd : 16'h0000));
	wire [15:0] next_rxdone = mb_ev_in.rx_done |
		(rxdone & ~(wr_rxd ? wd : 16'h0000));
	wire [15:0] next_remote = (mb_ev_in.rx_done & mb_ev_in.rx_remote) |
		(remote & ~(wr_rem ? wd : 16'h0000));

	// Set events of the interrupt flag register, one per bit.
	logic [15:0] flag_set;
	always_comb
	begin
		flag_set = 16'h0000;
		flag_set[`CMB_F_RESET_DONE] = 1'b0;
		flag_set[`CMB_F_TX_WARN]  = tx_warn & ~tx_warn_q;
		flag_set[`CMB_F_RX_WARN]  = rx_warn & ~rx_warn_q;
		flag_set[`CMB_F_PASSIVE]  = passive & ~passive_q;
		flag_set[`CMB_F_BUS_OFF]  = busoff & ~busoff_q;
		flag_set[`CMB_F_OVERLOAD] = ctl_ev_in.overload;
		flag_set[`CMB_F_MB_EMPTY] = |(tx_fin | can_fin);
		flag_set[`CMB_F_OVERWRITE] = ctl_ev_in.overwrite;
		flag_set[`CMB_F_BUS_ACT] = sleep_mode_in &
			ctl_ev_in.bus_activity;
	end

	// Write-one-to-clear bits of the flag register; the receive and
	// remote summaries are not cleared by software at all.
	wire [15:0] w1c_bits = 16'h13f9;
	wire [15:0] flag_clr = wr_irr ? (wd & w1c_bits) : 16'h0000;
	logic [15:0] next_iflags;
	always_comb
	begin
		next_iflags = flag_set | (iflags & ~flag_clr);
		next_iflags[`CMB_F_RX_MSG] = |next_rxdone;
		next_iflags[`CMB_F_REMOTE] = |next_remote;
		// Reset processing in progress reads as zero; completion sets.
		if (ctl_ev_in.reset_busy)
		begin
			next_iflags[`CMB_F_RESET_DONE] = 1'b0;
		end
		else if (iflags[`CMB_F_RESET_DONE] == 1'b0 && rst_seen)
		begin
			next_iflags[`CMB_F_RESET_DONE] = 1'b1;
		end
		next_iflags[15:13] = 3'h0;
		next_iflags[11:10] = 2'h0;
	end

	// Read data mux; unmapped addresses read zero.
	logic [15:0] rd_mux;
	always_comb
	begin
		unique case (avs_address_in)
			`CMB_OFS_DIRECTION: rd_mux = direction;
			`CMB_OFS_PENDING:   rd_mux = pending;
			`CMB_OFS_TRANSMIT_DONE_ACK:     rd_mux = transmit_done_ack;
			`CMB_OFS_CANCEL:    rd_mux = cancel;
			`CMB_OFS_CANCEL_DONE_ACK:     rd_mux = cancel_done_ack;
			`CMB_OFS_RXDONE:    rd_mux = rxdone;
			`CMB_OFS_REMOTE:    rd_mux = remote;
			`CMB_OFS_IFLAGS:    rd_mux = iflags;
			`CMB_OFS_IMASK:     rd_mux = imask;
			`CMB_OFS_CTRL:      rd_mux = {15'h0000, release_en};
			default:            rd_mux = 16'h0000;
		endcase
	end

	// Bus phase: a request waits one cycle, then is answered.
	// Read data is registered one cycle early from the held address,
	// so it stands at the edge where waitrequest is sampled low.
	// With no request pending the slave keeps waitrequest high.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			phase               <= cmb_pkg::CMB_IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h00000000;
		end
		else
		begin
			phase               <= (acc | !(avs_read_in | avs_write_in)) ?
				cmb_pkg::CMB_IDLE : cmb_pkg::CMB_ANS;
			avs_waitrequest_out <= !((avs_read_in | avs_write_in) & !acc);
			avs_readdata_out    <= {16'h0000, rd_mux};
		end
	end

	// Control registers written by software.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			direction  <= 16'h0000;
			imask      <= `CMB_IMASK_RESET;
			release_en <= 1'b0;
		end
		else
		begin
			if (wr_dir)
				direction <= wd & tx_mask;
			if (wr_imr)
				imask <= wd;
			if (wr_ctl)
				release_en <= wd[0];
		end
	end

	// Hardware-updated flag registers.
	// The threshold history registers sit here as well, so that a
	// counter that is already high after reset still raises its flag
	// once on the first cycle out of reset.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pending   <= 16'h0000;
			cancel    <= 16'h0000;
			transmit_done_ack     <= 16'h0000;
			cancel_done_ack     <= 16'h0000;
			rxdone    <= 16'h0000;
			remote    <= 16'h0000;
			iflags    <= `CMB_IFLAGS_RESET;
			tx_warn_q <= 1'b0;
			rx_warn_q <= 1'b0;
			passive_q <= 1'b0;
			busoff_q  <= 1'b0;
			rst_seen  <= 1'b0;
		end
		else
		begin
			pending   <= next_pending;
			cancel    <= next_cancel;
			transmit_done_ack     <= next_transmit_done_ack;
			cancel_done_ack     <= next_cancel_done_ack;
			rxdone    <= next_rxdone;
			remote    <= next_remote;
			iflags    <= next_iflags;
			tx_warn_q <= tx_warn;
			rx_warn_q <= rx_warn;
			passive_q <= passive;
			busoff_q  <= busoff;
			rst_seen  <= ctl_ev_in.reset_busy |
				(rst_seen & ~iflags[`CMB_F_RESET_DONE]);
		end
	end

	// Outputs toward the protocol engine and the interrupt line.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tx_request_out     <= 16'h0000;
			cancel_request_out <= 16'h0000;
			rx_enable_out      <= 16'h0001;
			sleep_release_out  <= 1'b0;
			irq_out            <= 1'b0;
		end
		else
		begin
			// Transmit mailboxes enter arbitration while pending.
			tx_request_out     <= next_pending & ~direction;
			cancel_request_out <= next_cancel;
			rx_enable_out      <= direction | 16'h0001;
			sleep_release_out  <= release_en & sleep_mode_in &
				ctl_ev_in.bus_activity;
			irq_out            <= |(next_iflags & ~imask);
		end
	end

	// Pending drops one cycle after a finished transmission.
	pend_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(mb_ev_in.tx_done[1] && pending[1]) |=> !pending[1] && transmit_done_ack[1])
		else $error("pending not cleared on completion");
	transmit_done_ack_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		|tx_fin |=> |transmit_done_ack)
		else $error("transmit ack not set");
	cancel_done_ack_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		|can_fin |=> (|cancel_done_ack) && iflags[`CMB_F_MB_EMPTY])
		else $error("abort ack or empty flag not set");
	rx_sum_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		iflags[`CMB_F_RX_MSG] == (|rxdone))
		else $error("receive summary mismatch");
	remote_sum_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		iflags[`CMB_F_REMOTE] == (|remote))
		else $error("remote summary mismatch");
	busoff_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(busoff) |=> iflags[`CMB_F_BUS_OFF])
		else $error("bus off flag not set");
	irq_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(imask == 16'hffff && $past(imask) == 16'hffff) |-> !irq_out)
		else $error("masked flag raised request");
	set_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(mb_ev_in.rx_done[0] && wr_rxd && wd[0]) |=> rxdone[0])
		else $error("clear beat a set event");
	warn_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(tx_warn) |=> iflags[`CMB_F_TX_WARN])
		else $error("transmit warning flag not set");

	// The direction bit of mailbox zero can never be set.
	dir_bit0_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!direction[0])
		else $error("mailbox zero direction bit set");

	// A pending write of one sets the bit at the answer edge.
	pend_start_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(wr_pend && wd[2]) |=> pending[2])
		else $error("pending bit not set by write");

	// A completed cancel drops pending and sets its acknowledge.
	cancel_clear_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(can_fin[1] && !wr_pend) |=> !pending[1] && cancel_done_ack[1])
		else $error("pending not cleared on cancel");

	// A frame that finished first leaves the abort acknowledge clear.
	abort_lose_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(tx_fin[1] && !cancel_done_ack[1]) |=> !cancel_done_ack[1])
		else $error("abort ack set after completion");

	// A received frame sets its receive-done bit.
	rx_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		mb_ev_in.rx_done[3] |=> rxdone[3])
		else $error("receive done not set");

	// A received remote frame sets its remote bit.
	remote_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(mb_ev_in.rx_done[3] && mb_ev_in.rx_remote[3]) |=> remote[3])
		else $error("remote bit not set");

	// Any completed transmission marks a mailbox empty.
	empty_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(|tx_fin) |=> iflags[`CMB_F_MB_EMPTY])
		else $error("mailbox empty flag not set");

	// Bus activity while asleep raises the activity flag.
	act_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(sleep_mode_in && ctl_ev_in.bus_activity) |=>
		iflags[`CMB_F_BUS_ACT])
		else $error("bus activity flag not set");

	// The receive counter crossing its warning limit raises a flag.
	rxwarn_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(rx_warn) |=> iflags[`CMB_F_RX_WARN])
		else $error("receive warning flag not set");

	// Either counter crossing the passive limit raises a flag.
	passive_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(passive) |=> iflags[`CMB_F_PASSIVE])
		else $error("error passive flag not set");

	// An overload frame raises the overload flag.
	overload_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		ctl_ev_in.overload |=> iflags[`CMB_F_OVERLOAD])
		else $error("overload flag not set");

	// Overwriting an unread message raises the overwrite flag.
	overwrite_set_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		ctl_ev_in.overwrite |=> iflags[`CMB_F_OVERWRITE])
		else $error("overwrite flag not set");

	// Reset-done reads zero while controller reset is in progress.
	reset_busy_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		ctl_ev_in.reset_busy |=> !iflags[`CMB_F_RESET_DONE])
		else $error("reset done flag set during reset");

	// Without the enable, bus activity never releases sleep.
	release_off_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!release_en |=> !sleep_release_out)
		else $error("sleep released while disabled");

	// A zero written to an acknowledge bit leaves it set.
	w1c_keep_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(wr_txa && !wd[2] && transmit_done_ack[2]) |=> transmit_done_ack[2])
		else $error("write of zero cleared a flag");
endmodule

//--- testbench/cmb_can_node.sv
`timescale 1ns/100ps
// Behavioural stand-in for the other nodes on the bus.
module cmb_can_node (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [15:0] tx_request_in,
	input  wire logic [15:0] cancel_request_in,
	input  wire logic [15:0] rx_pulse_in,
	input  wire logic [15:0] remote_pulse_in,
	input  wire logic [7:0]  delay_in,
	output cmb_pkg::cmb_mb_ev_t mb_ev_out
);
	logic [7:0]  count; // Cycles left in the current phase.
	logic [15:0] busy;  // Mailbox now on the wire, one-hot.
	logic [15:0] lowest;
	// Lowest requesting mailbox wins; one frame at a time keeps it simple.
	assign lowest = tx_request_in & (~tx_request_in + 16'h0001);
	// A hold-off after each frame lets the pending register fall first.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			busy      <= 16'h0000;
			count     <= 8'h00;
			mb_ev_out <= '0;
		end
		else
		begin
			mb_ev_out           <= '0;
			mb_ev_out.rx_done   <= rx_pulse_in;
			mb_ev_out.rx_remote <= remote_pulse_in;
			if (count != 8'h00)
				count <= count - 8'h01;
			if (busy == 16'h0000)
			begin
				if (count == 8'h00 && lowest != 16'h0000)
				begin
					busy  <= lowest;
					count <= delay_in;
				end
			end
			else if ((cancel_request_in & busy) != 16'h0000)
			begin
				mb_ev_out.cancel_done <= busy;
				busy  <= 16'h0000;
				count <= 8'h03;
			end
			else if (count == 8'h00)
			begin
				mb_ev_out.tx_done <= busy;
				busy  <= 16'h0000;
				count <= 8'h03;
			end
		end
	end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic        clk_in, rst_n_in, avs_read_in, avs_write_in, sleep_mode_in;
	logic [3:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out;
	logic        avs_waitrequest_out, sleep_release_out, irq_out;
	logic [15:0] tx_request_out, cancel_request_out, rx_enable_out;
	logic [15:0] rx_p, rm_p, b;
	logic [7:0]  dly;
	cmb_pkg::cmb_mb_ev_t  mb_ev;
	cmb_pkg::cmb_ctl_ev_t ctl;
	logic [15:0] exp_q[$]; // Expected read data, oldest first.
	int n_mismatch, num_checks;
	cmb_mailbox_flags dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .mb_ev_in(mb_ev),
		.ctl_ev_in(ctl), .sleep_mode_in(sleep_mode_in),
		.tx_request_out(tx_request_out),
		.cancel_request_out(cancel_request_out),
		.rx_enable_out(rx_enable_out),
		.sleep_release_out(sleep_release_out), .irq_out(irq_out));
	cmb_can_node node (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.tx_request_in(tx_request_out),
		.cancel_request_in(cancel_request_out), .rx_pulse_in(rx_p),
		.remote_pulse_in(rm_p), .delay_in(dly), .mb_ev_out(mb_ev));
	always #5 clk_in = ~clk_in;
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		num_checks++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// Read answers are compared in the cycle that carries them.
	always @(posedge clk_in)
		if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
			chk(avs_readdata_out[15:0], exp_q.pop_front());
	// One Avalon transfer, held until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		avs_address_in   <= a;
		avs_writedata_in <= {16'h0000, d};
		avs_read_in      <= ~wr;
		avs_write_in     <= wr;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (avs_waitrequest_out !== 1'b0 && n < 100);
		if (n >= 100)
			n_mismatch++;
		avs_read_in  <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 16'h0000);
	endtask
	// Waits for the mailbox to go quiet, then lets the flags land.
	task automatic settle;
		int n;
		n = 0;
		while (tx_request_out !== 16'h0000 && n < 600)
		begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 600)
			n_mismatch++;
		repeat (4) @(posedge clk_in);
	endtask
	task automatic pulse_ctl(input int which);
		ctl.overload     <= (which == 0);
		ctl.bus_activity <= (which == 1);
		ctl.overwrite    <= (which == 2);
		@(posedge clk_in);
		ctl.overwrite    <= 1'b0;
		ctl.overload     <= 1'b0;
		ctl.bus_activity <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	task print_verdict;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		n_mismatch++;
		print_verdict;
	end
	initial
	begin
		clk_in = 1'b0; rst_n_in = 1'b0; avs_read_in = 1'b0;
		avs_write_in = 1'b0; avs_address_in = 4'h0;
		avs_writedata_in = 32'h00000000; sleep_mode_in = 1'b0;
		rx_p = 16'h0000; rm_p = 16'h0000; dly = 8'h00; ctl = '0;
		n_mismatch = 0; num_checks = 0;
		void'($urandom(32'hf1665a08));
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(4'h7, 16'h0001);
		rd(4'h8, 16'hffff);
		rd(4'h0, 16'h0000);
		bus(1'b1, 4'h7, 16'h0001);
		rd(4'h7, 16'h0000);
		// Completed transmissions, short and long.
		repeat (3)
		begin
			b = 16'h0001 << (1 + $urandom % 15);
			dly = 8'($urandom % 40);
			bus(1'b1, 4'h1, b);
			settle();
			rd(4'h1, 16'h0000);
			rd(4'h2, b);
			rd(4'h4, 16'h0000);
			rd(4'h7, 16'h0100);
			bus(1'b1, 4'h2, 16'h0000);
			rd(4'h2, b);
			bus(1'b1, 4'h2, b);
			bus(1'b1, 4'h7, 16'h0100);
			rd(4'h2, 16'h0000);
		end
		// A slow frame is cancelled before it completes.
		dly = 8'hc8;
		b = 16'h0001 << (1 + $urandom % 15);
		bus(1'b1, 4'h1, b);
		bus(1'b1, 4'h3, b);
		chk(cancel_request_out, b);
		chk(tx_request_out, b);
		settle();
		rd(4'h4, b);
		rd(4'h2, 16'h0000);
		rd(4'h1, 16'h0000);
		rd(4'h7, 16'h0100);
		bus(1'b1, 4'h4, b);
		bus(1'b1, 4'h7, 16'h0100);
		bus(1'b1, 4'h0, b);
		rd(4'h0, b);
		chk(rx_enable_out, b | 16'h0001);
		// Remote frame into a random mailbox.
		b = 16'h0001 << ($urandom % 16);
		rx_p <= b;
		rm_p <= b;
		@(posedge clk_in);
		rx_p <= 16'h0000;
		rm_p <= 16'h0000;
		repeat (3) @(posedge clk_in);
		rd(4'h5, b);
		rd(4'h6, b);
		rd(4'h7, 16'h0006);
		bus(1'b1, 4'h5, b);
		rd(4'h7, 16'h0004);
		bus(1'b1, 4'h6, b);
		rd(4'h7, 16'h0000);
		// Error counters climb through each threshold.
		ctl.tec <= 9'h060;
		repeat (3) @(posedge clk_in);
		rd(4'h7, 16'h0008);
		ctl.rec <= 8'h60;
		repeat (3) @(posedge clk_in);
		rd(4'h7, 16'h0018);
		ctl.rec <= 8'h80;
		repeat (3) @(posedge clk_in);
		rd(4'h7, 16'h0038);
		ctl.tec <= 9'h100;
		repeat (3) @(posedge clk_in);
		rd(4'h7, 16'h0078);
		pulse_ctl(0);
		rd(4'h7, 16'h00f8);
		chk(irq_out, 16'h0000);
		bus(1'b1, 4'h8, 16'hff7f);
		repeat (2) @(posedge clk_in);
		chk(irq_out, 16'h0001);
		pulse_ctl(2);
		rd(4'h7, 16'h02f8);
		bus(1'b1, 4'h7, 16'h02f8);
		rd(4'h7, 16'h0000);
		sleep_mode_in <= 1'b1;
		pulse_ctl(1);
		rd(4'h7, 16'h1000);
		bus(1'b1, 4'h7, 16'h1000);
		bus(1'b1, 4'h9, 16'h0001);
		ctl.bus_activity <= 1'b1;
		@(posedge clk_in);
		ctl.bus_activity <= 1'b0;
		@(posedge clk_in);
		chk(sleep_release_out, 16'h0001);
		repeat (2) @(posedge clk_in);
		rd(4'h7, 16'h1000);
		bus(1'b1, 4'h7, 16'h1000);
		ctl.reset_busy <= 1'b1;
		repeat (2) @(posedge clk_in);
		rd(4'h7, 16'h0000);
		ctl.reset_busy <= 1'b0;
		repeat (3) @(posedge clk_in);
		rd(4'h7, 16'h0001);
		print_verdict;
	end
endmodule
